// *** rtl/bfifo_pkg.sv ***
// Package with constants and types for the buffered FIFO data path.
package bfifo_pkg;
    // ********************************************************************
    // Chip modes and data path selection
    // ********************************************************************
    typedef enum logic [1:0] {
        CHIP_SLEEP,
        CHIP_STANDBY,
        CHIP_RX,
        CHIP_TX
    } chip_mode_type;

    localparam logic [1:0] PATH_CONTINUOUS = 2'h0;
    localparam logic [1:0] PATH_BUFFERED   = 2'h1;

    // ********************************************************************
    // Field positions of the control bits
    // ********************************************************************
    localparam int TX_START_POS   = 4;
    localparam int FILL_CTRL_POS  = 6;
    localparam int FILL_METHOD_POS = 7;

    // ********************************************************************
    // Interrupt source codes
    // ********************************************************************
    localparam logic [1:0] SEL_NONE  = 2'h0;
    localparam logic [1:0] SEL_ONE   = 2'h1;
    localparam logic [1:0] SEL_TWO   = 2'h2;
    localparam logic [1:0] SEL_THREE = 2'h3;

    // ********************************************************************
    // Sizes and timing
    // ********************************************************************
    localparam int          BYTE_BITS   = 8;
    localparam int          DEPTH_MAX   = 64;
    localparam int          DEPTH_STEP  = 16;
    localparam logic [2:0]  BIT_LAST    = 3'h7;
    localparam logic [6:0]  COUNT_ZERO  = 7'h00;

    // Configuration carried as one group.
    typedef struct packed {
        logic [1:0] path_select;
        logic [1:0] fifo_size;
        logic [5:0] threshold;
        logic [7:0] fifo_tx_priority_reg;
        logic [1:0] rx_first_pin_select;
        logic [1:0] rx_second_pin_select;
        logic       tx_second_pin_select;
        logic       sync_match_enable;
    } config_type;

    // Event flags carried as one group.
    typedef struct packed {
        logic buffer_drained_event;
        logic buffer_full_event;
        logic transmit_finished_event;
        logic byte_stored_event;
        logic threshold_event;
    } events_type;
endpackage : bfifo_pkg

// *** rtl/buffered_mode_fifo_datapath.sv ***
// Buffered mode FIFO, bit shifter and interrupt pin mapping.
`timescale 1ns/1ps

module buffered_mode_fifo_datapath
    import bfifo_pkg::*;
#(
    parameter int DEPTH = 64
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Configuration
    input  wire bfifo_pkg::chip_mode_type chip_mode,
    input  wire bfifo_pkg::config_type  cfg,
    // Host data port
    input  wire logic                   wr_valid,
    input  wire logic [7:0]             wr_data,
    input  wire logic                   rd_req,
    output logic      [7:0]             rd_data,
    // Modem side
    input  wire logic                   bit_tick,
    input  wire logic                   rx_bit,
    input  wire logic                   sync_detected,
    input  wire logic                   signal_strength_indication,
    output logic                        tx_bit,
    output logic                        tx_active,
    // Status
    output logic                        bit_sync_enable,
    output logic                        packet_logic_enable,
    output logic                        receive_overflow_flag,
    output bfifo_pkg::events_type       events,
    output logic                        int_pin_a,
    output logic                        int_pin_b
);
    import bfifo_pkg::*;

    logic [7:0] mem [DEPTH];
    logic [5:0] wr_ptr_reg;
    logic [5:0] rd_ptr_reg;
    logic [6:0] count_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic       shift_full_reg;
    logic       tx_run_reg;
    logic       fill_reg;
    logic [6:0] depth_sel;
    logic       buffered;
    logic       in_tx;
    logic       fifo_empty;
    logic       fifo_full;
    logic       tx_load;
    logic       rx_push;
    logic       do_push;
    logic       do_pop;
    logic       wr_ok;
    logic       rx_byte_done;
    logic       tx_start_cond;

    // ********************************************************************
    // FIFO storage and pointers
    // ********************************************************************
    assign buffered  = (cfg.path_select == PATH_BUFFERED);
    assign in_tx     = buffered && (chip_mode == CHIP_TX);
    assign depth_sel = 7'(DEPTH_STEP) * {5'h00, cfg.fifo_size}
                       + 7'(DEPTH_STEP);
    assign fifo_empty = (count_reg == COUNT_ZERO);
    assign fifo_full  = (count_reg >= depth_sel);
    // Host writes are taken in standby and transmit only; receive blocks them and sleep clears the FIFO.
    assign wr_ok   = wr_valid && buffered && !fifo_full
                     && (chip_mode != CHIP_RX);
    assign tx_start_cond = cfg.fifo_tx_priority_reg[TX_START_POS]
                           ? !fifo_empty : fifo_full;
    assign tx_load = in_tx && bit_tick && !fifo_empty
                     && (tx_run_reg || tx_start_cond)
                     && (bit_cnt_reg == BIT_LAST || !shift_full_reg);
    assign rx_byte_done = buffered && chip_mode == CHIP_RX && fill_reg
                          && bit_tick && bit_cnt_reg == BIT_LAST;
    assign rx_push = rx_byte_done && !fifo_full;
    assign do_push = wr_ok || rx_push;
    // Reads allowed in receive and standby alike.
    assign do_pop = (rd_req && !fifo_empty && buffered
                     && !in_tx) || tx_load;

    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= wr_ok ? wr_data
                                     : {shift_reg[6:0], rx_bit};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= 6'h00;
            rd_ptr_reg <= 6'h00;
            count_reg  <= COUNT_ZERO;
        end else if ((buffered && chip_mode == CHIP_SLEEP)
                     || (tx_run_reg && !in_tx)) begin
            wr_ptr_reg <= 6'h00;
            rd_ptr_reg <= 6'h00;
            count_reg  <= COUNT_ZERO;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 6'h01;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 6'h01;
            end
            count_reg <= count_reg + {6'h00, do_push} - {6'h00, do_pop};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (do_pop && !tx_load) begin
            rd_data <= mem[rd_ptr_reg];
        end
    end

    // ********************************************************************
    // Bit shifter for transmit and receive
    // ********************************************************************
    // A leaving of transmit drops the shifter at once; unsent bits are lost.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_reg      <= 8'h00;
            bit_cnt_reg    <= 3'h0;
            shift_full_reg <= 1'b0;
            tx_run_reg     <= 1'b0;
            tx_bit         <= 1'b0;
        end else if (in_tx) begin
            if (tx_load) begin
                shift_reg      <= mem[rd_ptr_reg];
                bit_cnt_reg    <= 3'h0;
                shift_full_reg <= 1'b1;
                tx_run_reg     <= 1'b1;
                tx_bit         <= mem[rd_ptr_reg][BYTE_BITS-1];
            end else if (bit_tick && shift_full_reg) begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                tx_bit    <= shift_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == BIT_LAST) begin
                    shift_full_reg <= 1'b0;
                end
            end
        end else if (buffered && chip_mode == CHIP_RX && fill_reg) begin
            tx_run_reg <= 1'b0;
            tx_bit     <= 1'b0;
            if (bit_tick) begin
                shift_reg   <= {shift_reg[6:0], rx_bit};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
        end else begin
            shift_reg      <= 8'h00;
            bit_cnt_reg    <= 3'h0;
            shift_full_reg <= 1'b0;
            tx_run_reg     <= 1'b0;
            tx_bit         <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_active <= 1'b0;
        end else begin
            tx_active <= in_tx && (shift_full_reg || tx_load);
        end
    end

    // ********************************************************************
    // Receive fill control
    // ********************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fill_reg <= 1'b0;
        end else if (!buffered || chip_mode != CHIP_RX) begin
            fill_reg <= 1'b0;
        end else if (cfg.fifo_tx_priority_reg[FILL_METHOD_POS]) begin
            fill_reg <= cfg.fifo_tx_priority_reg[FILL_CTRL_POS];
        end else if (sync_detected) begin
            fill_reg <= 1'b1;
        end
    end

    // The overrun flag stays set until the chip leaves receive.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            receive_overflow_flag <= 1'b0;
        end else if (rx_byte_done && fifo_full && !rd_req) begin
            receive_overflow_flag <= 1'b1;
        end else if (chip_mode != CHIP_RX) begin
            receive_overflow_flag <= 1'b0;
        end
    end

    // ********************************************************************
    // Events and interrupt pins
    // ********************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            events           <= '0;
            bit_sync_enable  <= 1'b0;
            packet_logic_enable <= 1'b0;
        end else begin
            bit_sync_enable     <= buffered;
            packet_logic_enable <= 1'b0;
            events.buffer_drained_event <= fifo_empty
                || (tx_load && count_reg == 7'h01);
            events.buffer_full_event <= fifo_full;
            events.transmit_finished_event <= in_tx && tx_run_reg
                && !shift_full_reg && fifo_empty;
            events.byte_stored_event <= rx_push;
            events.threshold_event <=
                (count_reg >= {1'b0, cfg.threshold});
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            int_pin_a <= 1'b0;
            int_pin_b <= 1'b0;
        end else if (!buffered) begin
            int_pin_a <= 1'b0;
            int_pin_b <= 1'b0;
        end else if (chip_mode == CHIP_TX) begin
            int_pin_a <= events.buffer_drained_event;
            int_pin_b <= cfg.tx_second_pin_select
                ? events.transmit_finished_event
                : events.buffer_full_event;
        end else begin
            unique case (cfg.rx_first_pin_select)
                SEL_NONE:  int_pin_a <= 1'b0;
                SEL_ONE:   int_pin_a <= (chip_mode == CHIP_RX)
                                        && events.byte_stored_event;
                SEL_TWO:   int_pin_a <= events.buffer_drained_event;
                SEL_THREE: int_pin_a <= (chip_mode == CHIP_RX)
                                        && fill_reg;
            endcase
            unique case (cfg.rx_second_pin_select)
                SEL_NONE:  int_pin_b <= 1'b0;
                SEL_ONE:   int_pin_b <= events.buffer_full_event;
                SEL_TWO:   int_pin_b <= (chip_mode == CHIP_RX)
                                        && signal_strength_indication;
                SEL_THREE: int_pin_b <= events.threshold_event;
            endcase
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    property p_overrun;
        @(posedge sys_clk) disable iff (rst)
        (rx_byte_done && fifo_full && !rd_req) |=> receive_overflow_flag;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("Overrun not flagged.");

    property p_no_pack;
        @(posedge sys_clk) disable iff (rst)
        ##1 !packet_logic_enable;
    endproperty
    a_no_pack: assert property (p_no_pack)
        else $error("Packet logic enabled.");

    property p_sync;
        @(posedge sys_clk) disable iff (rst)
        buffered |=> bit_sync_enable;
    endproperty
    a_sync: assert property (p_sync)
        else $error("Bit synchronizer off.");

    property p_bound;
        @(posedge sys_clk) disable iff (rst)
        count_reg <= depth_sel;
    endproperty
    a_bound: assert property (p_bound)
        else $error("FIFO over depth.");

    property p_full;
        @(posedge sys_clk) disable iff (rst)
        fifo_full |=> events.buffer_full_event;
    endproperty
    a_full: assert property (p_full)
        else $error("Full event missing.");

    property p_abort;
        @(posedge sys_clk) disable iff (rst)
        (buffered && chip_mode == CHIP_STANDBY) |=> !tx_active;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Transmit still active.");

    property p_txpin;
        @(posedge sys_clk) disable iff (rst)
        (in_tx && $stable(chip_mode)) |=>
            int_pin_a == $past(events.buffer_drained_event);
    endproperty
    a_txpin: assert property (p_txpin)
        else $error("Transmit pin a wrong.");

    property p_thr;
        @(posedge sys_clk) disable iff (rst)
        (count_reg < {1'b0, cfg.threshold}) |=> !events.threshold_event;
    endproperty
    a_thr: assert property (p_thr)
        else $error("Threshold event early.");

    c_tx: cover property (@(posedge sys_clk) tx_load ##[1:300] tx_active);
    c_ovr: cover property (@(posedge sys_clk) $rose(receive_overflow_flag));
    c_done: cover property (@(posedge sys_clk)
        $rose(events.transmit_finished_event));
endmodule : buffered_mode_fifo_datapath

// *** verif/bit_link_model.sv ***
// Modem side model: bit clock, received bit stream and sent byte capture.
`timescale 1ns/1ps
module bit_link_model #(
    parameter int BIT_CYC = 8
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Bit clock gate
    input  wire logic tick_en,
    // Bit stream
    output logic      bit_tick,
    output logic      rx_bit,
    input  wire logic tx_bit,
    input  wire logic tx_active
);
    int         cnt, idx, tx_n;
    logic       have, noise;
    logic [7:0] cur, sh;
    logic [7:0] rx_q[$];
    logic [7:0] tx_q[$];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            bit_tick <= 1'b0;
        end else begin
            cnt <= (!tick_en || cnt == BIT_CYC - 1) ? 0 : cnt + 1;
            bit_tick <= tick_en && cnt == BIT_CYC - 1;
        end
    end

    // An idle line toggles every bit, so a stale level never looks valid.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            have <= 1'b0;
            idx <= 0;
            noise <= 1'b0;
        end else begin
            noise <= noise ^ bit_tick;
            if ((!have || (bit_tick && idx == 7)) && rx_q.size() > 0) begin
                cur <= rx_q.pop_front();
                have <= 1'b1;
                idx <= 0;
            end else if (bit_tick && have) begin
                idx <= idx + 1;
                have <= idx != 7;
            end
        end
    end
    assign rx_bit = have ? cur[7 - idx] : noise;

    // Partial bytes are dropped whenever sending stops.
    always_ff @(posedge sys_clk) begin
        if (rst || !tx_active) begin
            tx_n <= 0;
        end else if (bit_tick) begin
            sh <= {sh[6:0], tx_bit};
            tx_n <= (tx_n == 7) ? 0 : tx_n + 1;
            if (tx_n == 7)
                tx_q.push_back({sh[6:0], tx_bit});
        end
    end
endmodule : bit_link_model

// *** verif/test_buffered_mode_fifo_datapath.sv ***
// Self-checking bench for the buffered FIFO data path.
`timescale 1ns/1ps
module test_buffered_mode_fifo_datapath;
    import bfifo_pkg::*;
    localparam int BIT_CYC = 8;
    typedef enum int {F_ACT, F_DRAIN, F_DONE, F_FULL, F_OVR, F_THR,
        F_PINA} flag_type;
    chip_mode_type chip_mode;
    config_type    cfg;
    events_type    events;
    logic          sys_clk, rst, wr_valid, rd_req, bit_tick, rx_bit;
    logic          sync_det, strength, tx_bit, tx_active, bsync, pkt;
    logic          ovf, int_pin_a, int_pin_b, tick_en;
    logic [7:0]    wr_data, rd_data;
    logic [7:0]    exp_q[$];
    int            num_errors, compares;

    buffered_mode_fifo_datapath #(
        .DEPTH(64)
    ) u_buffered_mode_fifo_datapath (
        .sys_clk(sys_clk), .rst(rst), .chip_mode(chip_mode), .cfg(cfg),
        .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req),
        .rd_data(rd_data), .bit_tick(bit_tick), .rx_bit(rx_bit),
        .sync_detected(sync_det), .signal_strength_indication(strength),
        .tx_bit(tx_bit), .tx_active(tx_active), .bit_sync_enable(bsync),
        .packet_logic_enable(pkt), .receive_overflow_flag(ovf),
        .events(events), .int_pin_a(int_pin_a), .int_pin_b(int_pin_b)
    );
    bit_link_model #(
        .BIT_CYC(BIT_CYC)
    ) u_bit_link_model (
        .sys_clk(sys_clk), .rst(rst), .tick_en(tick_en), .bit_tick(bit_tick),
        .rx_bit(rx_bit), .tx_bit(tx_bit), .tx_active(tx_active)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ******************************
    // Access and compare helpers
    // ******************************
    task automatic print_verdict;
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    function automatic logic flag(input flag_type w);
        case (w)
            F_ACT:   return tx_active;
            F_DRAIN: return events.buffer_drained_event;
            F_DONE:  return events.transmit_finished_event;
            F_FULL:  return events.buffer_full_event;
            F_OVR:   return ovf;
            F_THR:   return events.threshold_event;
            default: return int_pin_a;
        endcase
    endfunction : flag

    // Bounded wait; running out of time shows up as a mismatch.
    task automatic wait_flag(input flag_type w, input logic lvl);
        int n;
        n = 0;
        while (flag(w) !== lvl && n < 3000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(flag(w), lvl);
    endtask : wait_flag

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] d, input logic keep);
        @(posedge sys_clk);
        wr_valid <= 1'b1;
        wr_data <= d;
        if (keep)
            exp_q.push_back(d);
        @(posedge sys_clk);
        wr_valid <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] want);
        @(posedge sys_clk);
        rd_req <= 1'b1;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        cyc(2);
        check(rd_data, want);
    endtask : rd

    task automatic check_tx;
        check(8'(u_bit_link_model.tx_q.size()), 8'(exp_q.size()));
        foreach (exp_q[i])
            check(u_bit_link_model.tx_q[i], exp_q[i]);
        u_bit_link_model.tx_q.delete();
        exp_q.delete();
    endtask : check_tx

    // Returns just after a bit tick, so a new byte lines up with bit one.
    task automatic align;
        do begin
            @(posedge sys_clk);
            #1;
        end while (bit_tick !== 1'b1);
        @(posedge sys_clk);
    endtask : align

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        chip_mode = CHIP_STANDBY;
        cfg = '0;
        cfg.path_select = PATH_BUFFERED;
        cfg.sync_match_enable = 1'b1;
        {wr_valid, rd_req, sync_det, strength} = 4'h0;
        wr_data = 8'h00;
        tick_en = 1'b1;
        num_errors = 0;
        compares = 0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(3);
        check(pkt, 1'b0);
        check(bsync, 1'b1);
        @(posedge sys_clk);
        cfg.fifo_tx_priority_reg[TX_START_POS] <= 1'b1;
        cfg.tx_second_pin_select <= 1'b1;
        chip_mode <= CHIP_TX;
        for (int i = 0; i < 3; i++)
            wr(8'hA0 + 8'(i), 1'b1);
        wait_flag(F_ACT, 1'b1);
        wait_flag(F_DRAIN, 1'b1);
        check(events.transmit_finished_event, 1'b0);
        wr(8'h5C, 1'b1);
        wait_flag(F_DONE, 1'b1);
        cyc(2);
        check(int_pin_a, 1'b1);
        check(int_pin_b, 1'b1);
        check_tx();
        cyc(BIT_CYC);
        @(posedge sys_clk);
        chip_mode <= CHIP_STANDBY;
        cfg.fifo_tx_priority_reg[TX_START_POS] <= 1'b0;
        cfg.tx_second_pin_select <= 1'b0;
        @(posedge sys_clk);
        chip_mode <= CHIP_TX;
        for (int i = 0; i < 15; i++)
            wr(8'(i), 1'b1);
        cyc(3 * BIT_CYC);
        check(tx_active, 1'b0);
        @(posedge sys_clk);
        tick_en <= 1'b0;
        wr(8'h0F, 1'b1);
        wr(8'hFF, 1'b0);
        cyc(3);
        check(events.buffer_full_event, 1'b1);
        check(int_pin_b, 1'b1);
        check(tx_active, 1'b0);
        @(posedge sys_clk);
        tick_en <= 1'b1;
        wait_flag(F_ACT, 1'b1);
        wait_flag(F_DONE, 1'b1);
        check_tx();
        cyc(BIT_CYC);
        @(posedge sys_clk);
        cfg.fifo_tx_priority_reg[TX_START_POS] <= 1'b1;
        wr(8'h11, 1'b0);
        wr(8'h22, 1'b0);
        wait_flag(F_ACT, 1'b1);
        repeat (3 * BIT_CYC) @(posedge sys_clk);
        chip_mode <= CHIP_STANDBY;
        cyc(3);
        check(tx_active, 1'b0);
        check(events.buffer_drained_event, 1'b1);
        check(8'(u_bit_link_model.tx_q.size()), 8'h00);
        @(posedge sys_clk);
        chip_mode <= CHIP_RX;
        cfg.threshold <= 6'h04;
        cfg.fifo_tx_priority_reg[FILL_METHOD_POS] <= 1'b1;
        cfg.rx_first_pin_select <= SEL_ONE;
        cfg.rx_second_pin_select <= SEL_ONE;
        align();
        for (int i = 0; i < 18; i++)
            u_bit_link_model.rx_q.push_back(8'h30 + 8'(i));
        cfg.fifo_tx_priority_reg[FILL_CTRL_POS] <= 1'b1;
        wait_flag(F_PINA, 1'b1);
        wait_flag(F_THR, 1'b1);
        wait_flag(F_FULL, 1'b1);
        check(ovf, 1'b0);
        wait_flag(F_OVR, 1'b1);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            cfg.rx_first_pin_select <= 2'(i);
            cfg.rx_second_pin_select <= 2'(i);
            strength <= 1'b1;
            cyc(3);
            if (i != 1)
                check(int_pin_a, i == 3);
            check(int_pin_b, i != 0);
        end
        @(posedge sys_clk);
        chip_mode <= CHIP_STANDBY;
        cfg.fifo_tx_priority_reg[FILL_CTRL_POS] <= 1'b0;
        cfg.rx_first_pin_select <= SEL_TWO;
        for (int i = 0; i < 16; i++) begin
            rd(8'h30 + 8'(i));
            check(events.threshold_event, i < 12);
        end
        cyc(2);
        check(int_pin_a, 1'b1);
        @(posedge sys_clk);
        chip_mode <= CHIP_RX;
        cfg.fifo_tx_priority_reg[FILL_METHOD_POS] <= 1'b0;
        align();
        u_bit_link_model.rx_q.push_back(8'h96);
        u_bit_link_model.rx_q.push_back(8'h69);
        sync_det <= 1'b1;
        @(posedge sys_clk);
        sync_det <= 1'b0;
        repeat (17 * BIT_CYC) @(posedge sys_clk);
        chip_mode <= CHIP_STANDBY;
        rd(8'h96);
        rd(8'h69);
        print_verdict();
    end
endmodule : test_buffered_mode_fifo_datapath
